// ===== rtl/wait_oneshot_timer_control.sv
// wait one-shot timer: control, status, start, interrupt and pin mapping
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps

// Operation
// - two-bit priority field; value 01 selects interrupt level one
// - pin 1.3 carries the timer wave when map bits 7 and 6 both one
// - writing one to control bit 0 requests counting to begin
// - control bit 1 reads count status, following start after a delay
// - one-shot control bit 2 reads one during wait and pulse
// - writing one to one-shot bit 0 launches a one-shot; reads zero
// - interrupt control bit 6 is the request flag; handler clears it
// - both mode select bits one selects programmable wait one-shot mode
// - output level select zero: high in pulse, low at stop and wait
// - writing one to control bit 2 stops counting at once; reads zero
// - interrupt control bit 7 enables the timer interrupt
module wait_oneshot_timer_control (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire wait_timer_pkg::reg_req_type req,
   output logic [7:0] rdata,
   // pin and interrupt
   output logic port1_pin3,
   output logic port1_pin3_oe,
   output logic timer_wave_out,
   output logic irq,
   output logic [1:0] irq_level
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] prio_reg;
   logic [7:0] port_map_reg;
   logic count_start_reg;
   logic [wait_timer_pkg::start_delay_cycles-1:0] start_pipe_reg;
   logic irq_enable_reg;
   logic irq_flag_reg;
   logic [1:0] mode_reg;
   logic out_level_reg;
   logic [7:0] wait_len_reg;
   logic [7:0] pulse_len_reg;
   logic [7:0] prescale_reg;
   logic [7:0] pre_cnt_reg;
   logic [7:0] cnt_reg;
   logic [7:0] rdata_next;
   wait_timer_pkg::oneshot_state_type state_reg;
   wait_timer_pkg::oneshot_state_type state_next;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic wr_at(input wait_timer_pkg::reg_req_type r,
                                  input logic [3:0] off);
      wr_at = r.wr && (r.addr == off);
   endfunction

   function automatic logic [1:0] bit_pair(input logic [7:0] v,
                                           input int hi, input int lo);
      bit_pair = {v[hi], v[lo]};
   endfunction

   wire wr_prio = wr_at(req, wait_timer_pkg::prio_level_c_offset);
   wire wr_map = wr_at(req, wait_timer_pkg::port1_map0_offset);
   wire wr_ctrl = wr_at(req, wait_timer_pkg::timer_control_offset);
   wire wr_os = wr_at(req, wait_timer_pkg::oneshot_control_offset);
   wire wr_irq = wr_at(req, wait_timer_pkg::irq_control_offset);
   wire wr_mode = wr_at(req, wait_timer_pkg::timer_mode_offset);
   wire wr_lvl = wr_at(req, wait_timer_pkg::output_level_offset);
   wire wr_wait = wr_at(req, wait_timer_pkg::wait_period_offset);
   wire wr_pulse = wr_at(req, wait_timer_pkg::pulse_width_offset);
   wire wr_pre = wr_at(req, wait_timer_pkg::prescale_offset);

   wire stop_req = wr_ctrl &&
      req.wdata[wait_timer_pkg::forced_stop_pos];
   wire start_bit = req.wdata[wait_timer_pkg::count_start_pos];
   wire counting = start_pipe_reg[wait_timer_pkg::start_delay_cycles-1];
   wire mode_ok = (mode_reg == wait_timer_pkg::op_mode_wait_oneshot);
   wire os_active = (state_reg != wait_timer_pkg::os_idle);
   // start ignored while a sequence runs
   wire os_launch = wr_os && req.wdata[wait_timer_pkg::oneshot_start_pos] &&
      !os_active && counting && mode_ok;
   // forced stop ends the sequence in the cycle it is written
   wire run = counting && !stop_req;
   wire pre_tick = run && (pre_cnt_reg == 8'h00);
   wire cnt_done = pre_tick && (cnt_reg == 8'h00);
   wire pulse_end = (state_reg == wait_timer_pkg::os_pulse) && cnt_done;
   wire irq_clr = wr_irq && !req.wdata[wait_timer_pkg::irq_request_pos];

   // ----------------------------------------------------------------
   // one-shot sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         wait_timer_pkg::os_idle: begin
            if (os_launch) begin
               state_next = wait_timer_pkg::os_wait;
            end
         end
         wait_timer_pkg::os_wait: begin
            if (cnt_done) begin
               state_next = wait_timer_pkg::os_pulse;
            end
         end
         wait_timer_pkg::os_pulse: begin
            if (cnt_done) begin
               state_next = wait_timer_pkg::os_idle;
            end
         end
         default: begin
            state_next = wait_timer_pkg::os_idle;
         end
      endcase
      if (!run) begin
         state_next = wait_timer_pkg::os_idle;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= wait_timer_pkg::os_idle;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // prescaler and wait/pulse counter
   // ----------------------------------------------------------------
   // prescaler reloads while idle so a launch starts a full tick
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_reg <= wait_timer_pkg::prescale_reset;
      end else if (os_launch || !os_active || pre_tick) begin
         pre_cnt_reg <= prescale_reg;
      end else begin
         pre_cnt_reg <= pre_cnt_reg - 8'h01;
      end
   end

   // wait length on launch, pulse length on each underflow
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= wait_timer_pkg::reg_reset;
      end else if (os_launch) begin
         cnt_reg <= wait_len_reg;
      end else if (cnt_done) begin
         cnt_reg <= pulse_len_reg;
      end else if (pre_tick) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // count start and status
   // ----------------------------------------------------------------
   // stop wins over a start written in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_start_reg <= 1'b0;
      end else if (stop_req) begin
         count_start_reg <= 1'b0;
      end else if (wr_ctrl) begin
         count_start_reg <= start_bit;
      end
   end

   // start reaches the status flag after the pipe delay
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_pipe_reg <= '0;
      end else if (stop_req) begin
         start_pipe_reg <= '0;
      end else begin
         start_pipe_reg <=
            {start_pipe_reg[wait_timer_pkg::start_delay_cycles-2:0],
             count_start_reg};
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prio_reg <= wait_timer_pkg::reg_reset;
      end else if (wr_prio) begin
         prio_reg <= req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port_map_reg <= wait_timer_pkg::reg_reset;
      end else if (wr_map) begin
         port_map_reg <= req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // mode and output level
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= 2'h0;
      end else if (wr_mode) begin
         mode_reg <= bit_pair(req.wdata, wait_timer_pkg::op_mode_sel1_pos,
                            wait_timer_pkg::op_mode_sel0_pos);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_level_reg <= 1'b0;
      end else if (wr_lvl) begin
         out_level_reg <= req.wdata[wait_timer_pkg::output_level_pos];
      end
   end

   // ----------------------------------------------------------------
   // timing registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_len_reg <= wait_timer_pkg::reg_reset;
      end else if (wr_wait) begin
         wait_len_reg <= req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_len_reg <= wait_timer_pkg::reg_reset;
      end else if (wr_pulse) begin
         pulse_len_reg <= req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prescale_reg <= wait_timer_pkg::prescale_reset;
      end else if (wr_pre) begin
         prescale_reg <= req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // interrupt enable and request flag
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_reg <= 1'b0;
      end else if (wr_irq) begin
         irq_enable_reg <= req.wdata[wait_timer_pkg::irq_enable_pos];
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_flag_reg <= 1'b0;
      end else if (pulse_end) begin
         irq_flag_reg <= 1'b1;
      end else if (irq_clr) begin
         irq_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      if (req.rd) begin
         case (req.addr)
            wait_timer_pkg::prio_level_c_offset: rdata_next = prio_reg;
            wait_timer_pkg::port1_map0_offset: rdata_next = port_map_reg;
            wait_timer_pkg::timer_control_offset: begin
               rdata_next[wait_timer_pkg::count_start_pos] = count_start_reg;
               rdata_next[wait_timer_pkg::count_status_pos] = counting;
               // stop bit has no storage and reads zero
            end
            wait_timer_pkg::oneshot_control_offset: begin
               rdata_next[wait_timer_pkg::oneshot_status_pos] =
                  os_active;
               // start bit has no storage and reads zero
            end
            wait_timer_pkg::irq_control_offset: begin
               rdata_next[wait_timer_pkg::irq_enable_pos] = irq_enable_reg;
               rdata_next[wait_timer_pkg::irq_request_pos] = irq_flag_reg;
            end
            wait_timer_pkg::timer_mode_offset: rdata_next[1:0] = mode_reg;
            wait_timer_pkg::output_level_offset: begin
               rdata_next[wait_timer_pkg::output_level_pos] = out_level_reg;
            end
            wait_timer_pkg::wait_period_offset: rdata_next = wait_len_reg;
            wait_timer_pkg::pulse_width_offset: rdata_next = pulse_len_reg;
            wait_timer_pkg::prescale_offset: rdata_next = prescale_reg;
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // pin follows the wave only while both select bits are set
   wire pin_mapped = (bit_pair(port_map_reg,
      wait_timer_pkg::pin13_sel_high_pos,
      wait_timer_pkg::pin13_sel_low_pos) ==
      wait_timer_pkg::pin13_sel_timer);
   // level select inverts; zero gives high pulse, low otherwise
   wire wave_next = (state_next == wait_timer_pkg::os_pulse) ^
      out_level_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timer_wave_out <= 1'b0;
      end else begin
         timer_wave_out <= wave_next;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rdata_next;
      end
   end

   assign port1_pin3 = pin_mapped & timer_wave_out;
   assign port1_pin3_oe = pin_mapped;
   // level request while flag and enable are both set
   assign irq = irq_flag_reg & irq_enable_reg;
   assign irq_level = prio_reg[1:0];

endmodule

// ===== rtl/wait_timer_pkg.sv
// package: register map, fields, states and timing for the wait one-shot timer
package wait_timer_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte-wide registers)
   // ----------------------------------------------------------------
   localparam logic [3:0] prio_level_c_offset = 4'h0;
   localparam logic [3:0] port1_map0_offset = 4'h1;
   localparam logic [3:0] timer_control_offset = 4'h2;
   localparam logic [3:0] oneshot_control_offset = 4'h3;
   localparam logic [3:0] irq_control_offset = 4'h4;
   localparam logic [3:0] timer_mode_offset = 4'h5;
   localparam logic [3:0] output_level_offset = 4'h6;
   localparam logic [3:0] wait_period_offset = 4'h7;
   localparam logic [3:0] pulse_width_offset = 4'h8;
   localparam logic [3:0] prescale_offset = 4'h9;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int count_start_pos = 0;
   localparam int count_status_pos = 1;
   localparam int forced_stop_pos = 2;
   localparam int oneshot_start_pos = 0;
   localparam int oneshot_status_pos = 2;
   localparam int irq_request_pos = 6;
   localparam int irq_enable_pos = 7;
   localparam int pin13_sel_low_pos = 6;
   localparam int pin13_sel_high_pos = 7;
   localparam int op_mode_sel0_pos = 0;
   localparam int op_mode_sel1_pos = 1;
   localparam int output_level_pos = 0;

   // ----------------------------------------------------------------
   // encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] prio_level_one = 2'h1;
   localparam logic [1:0] pin13_sel_timer = 2'h3;
   localparam logic [1:0] op_mode_wait_oneshot = 2'h3;
   localparam logic [7:0] reg_reset = 8'h00;
   localparam logic [7:0] prescale_reset = 8'h00;

   // ----------------------------------------------------------------
   // timing: start reaches the status flag after a sync delay
   // ----------------------------------------------------------------
   localparam int start_delay_ns = 20;
   localparam int clock_period_ns = 10;
   localparam int start_delay_cycles =
      (start_delay_ns + clock_period_ns - 1) / clock_period_ns;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      os_idle = 2'b00,
      os_wait = 2'b01,
      os_pulse = 2'b11
   } oneshot_state_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

endpackage

// ===== verification/wait_oneshot_timer_assertions.sv
// checker: port-level assertions for the wait one-shot timer control block
`timescale 1ns/10ps
module oneshot_timer_checks (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire wait_timer_pkg::reg_req_type req,
   input wire logic [7:0] rdata,
   // pin and interrupt
   input wire logic port1_pin3,
   input wire logic port1_pin3_oe,
   input wire logic timer_wave_out,
   input wire logic irq,
   input wire logic [1:0] irq_level
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // register side effects
   // ----------------------------------------------------------------
   a_level_one_set: assert property (
      req.wr && req.addr == 4'h0 && req.wdata[1:0] == 2'h1
      |=> irq_level == 2'h1)
      else $error("priority field not level one after write");
   a_pin_map_on: assert property (
      req.wr && req.addr == 4'h1 && req.wdata[7:6] == 2'h3
      |=> port1_pin3_oe)
      else $error("pin not mapped after map write");
   a_pin_follows_wave: assert property (
      port1_pin3 == (port1_pin3_oe & timer_wave_out))
      else $error("pin level does not follow wave");
   a_stop_reads_zero: assert property (
      req.rd && req.addr == 4'h2 |=> rdata[2] == 1'b0)
      else $error("forced stop bit read back one");
   a_start_reads_zero: assert property (
      req.rd && req.addr == 4'h3 |=> rdata[0] == 1'b0)
      else $error("one-shot start bit read back one");
   a_irq_gate_off: assert property (
      req.wr && req.addr == 4'h4 && !req.wdata[7] |=> !irq)
      else $error("interrupt high while disabled");
   a_stop_drops_wave: assert property (
      req.wr && req.addr == 4'h2 && req.wdata[2]
      |=> !timer_wave_out)
      else $error("wave still high after forced stop");
   a_read_idle_zero: assert property (
      !req.rd |=> rdata == 8'h00)
      else $error("read data nonzero outside read answer");
endmodule

bind wait_oneshot_timer_control oneshot_timer_checks chk_u (
   .mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
   .port1_pin3(port1_pin3), .port1_pin3_oe(port1_pin3_oe),
   .timer_wave_out(timer_wave_out), .irq(irq), .irq_level(irq_level)
);

// ===== verification/wait_oneshot_timer_control_bench.sv
// self-checking bench for the wait one-shot timer control block
`timescale 1ns/10ps
module wait_oneshot_timer_control_bench;
   // ----------------------------------------------------------------
   // signals and instance
   // ----------------------------------------------------------------
   localparam logic [3:0] o_ctl = wait_timer_pkg::timer_control_offset;
   localparam logic [3:0] o_os = wait_timer_pkg::oneshot_control_offset;
   localparam logic [3:0] o_irq = wait_timer_pkg::irq_control_offset;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   wait_timer_pkg::reg_req_type req = '0;
   logic [7:0] rdata;
   logic port1_pin3;
   logic port1_pin3_oe;
   logic timer_wave_out;
   logic irq;
   logic [1:0] irq_level;
   logic [7:0] rd_val;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   initial begin
      forever #5 mclk = ~mclk;
   end
   wait_oneshot_timer_control dut_u (
      .mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .port1_pin3(port1_pin3), .port1_pin3_oe(port1_pin3_oe),
      .timer_wave_out(timer_wave_out), .irq(irq), .irq_level(irq_level)
   );
   // ----------------------------------------------------------------
   // access and compare tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 rd_val = rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] exp);
      rd(a);
      check(rd_val, exp);
   endtask
   task automatic poll_count();
      rd_val = 8'h00;
      for (int k = 0; k < 8 && rd_val[1] !== 1'b1; k++) begin
         rd(o_ctl);
      end
      check(rd_val, 8'h03);
   endtask
   task automatic wait_wave(input logic v);
      for (int i = 0; i < 1000 && timer_wave_out !== v; i++) begin
         @(posedge mclk);
         #1;
      end
      check({7'h00, timer_wave_out}, {7'h00, v});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         rc(4'(i), 8'h00);
      end
      wr(4'hf, 8'hff);
      rc(4'hf, 8'h00);
      wr(4'h0, 8'h01);
      check({6'h00, irq_level}, 8'h01);
      rc(4'h0, 8'h01);
      wr(4'h1, 8'h40);
      check({7'h00, port1_pin3_oe}, 8'h00);
      wr(4'h1, 8'hc0);
      check({7'h00, port1_pin3_oe}, 8'h01);
      wr(4'h5, 8'h03);
      wr(4'h6, 8'h00);
      wr(4'h7, 8'h20);
      wr(4'h8, 8'h10);
      wr(o_irq, 8'h80);
      wr(o_os, 8'h01);
      rc(o_os, 8'h00);
      wr(o_ctl, 8'h01);
      poll_count();
      rc(o_os, 8'h00);
      wr(o_os, 8'h01);
      check({7'h00, timer_wave_out}, 8'h00);
      rc(o_os, 8'h04);
      wr(o_os, 8'h01);
      rc(o_os, 8'h04);
      wait_wave(1'b1);
      rc(o_os, 8'h04);
      wait_wave(1'b0);
      rc(o_os, 8'h00);
      rc(o_irq, 8'hc0);
      check({7'h00, irq}, 8'h01);
      wr(o_irq, 8'hc0);
      check({7'h00, irq}, 8'h01);
      wr(o_irq, 8'h80);
      check({7'h00, irq}, 8'h00);
      rc(o_irq, 8'h80);
      wr(o_irq, 8'h00);
      wr(o_os, 8'h01);
      wait_wave(1'b1);
      wait_wave(1'b0);
      rc(o_irq, 8'h40);
      check({7'h00, irq}, 8'h00);
      wr(o_irq, 8'hc0);
      check({7'h00, irq}, 8'h01);
      wr(o_irq, 8'h00);
      wr(o_os, 8'h01);
      wr(o_ctl, 8'h04);
      rc(o_ctl, 8'h00);
      rc(o_os, 8'h00);
      check({7'h00, timer_wave_out}, 8'h00);
      wr(o_ctl, 8'h01);
      poll_count();
      wr(4'h5, 8'h01);
      wr(o_os, 8'h01);
      rc(o_os, 8'h00);
      wr(4'h5, 8'h03);
      wr(o_os, 8'h01);
      rc(o_os, 8'h04);
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
      #1;
      check({5'h00, port1_pin3_oe, irq_level}, 8'h00);
      check({6'h00, irq, timer_wave_out}, 8'h00);
      @(posedge mclk);
      rst_n <= 1'b1;
      rc(o_os, 8'h00);
      rc(4'h0, 8'h00);
      rc(4'h1, 8'h00);
      tally_and_finish();
   end
endmodule
